// >>> tsc_pkg.sv
// Shared constants and types for the time-base and stamp counter block.
package tsc_pkg;

    localparam int NCH = 36;
    localparam int SEL_W = 6;
    localparam int NSTAMP = 6;
    localparam int INT_W = 17;
    localparam int FRAC_W = 10;
    localparam int ANT_DIV_W = 10;
    localparam int TEST_W = 19;

    localparam logic [7:0] OFS_EPOCH_DIV = 8'h0C;
    localparam logic [7:0] OFS_ANT_CTRL = 8'h18;
    localparam logic [7:0] OFS_EXT_CFG = 8'h1C;
    localparam logic [7:0] OFS_EXT_LIVE = 8'h20;
    localparam logic [7:0] OFS_EXT_HELD = 8'h24;
    localparam logic [7:0] OFS_TIME_LOW = 8'h28;
    localparam logic [7:0] OFS_TIME_HIGH = 8'h2C;
    localparam logic [7:0] OFS_STAMP_BASE = 8'h30;
    localparam logic [7:0] OFS_STAMP_LAST = 8'h5C;
    localparam logic [7:0] OFS_TEST = 8'h60;
    localparam logic [5:0] STAMP_WORD_BASE = 6'h0C;

    localparam int INT_LSB = 10;
    localparam int INT_MSB = 26;
    localparam int FRAC_MSB = 9;
    localparam int ANT_EN_BIT = 10;
    localparam int ANT_DIV_MSB = 9;
    localparam int LATCH_PPS_BIT = 3;
    localparam int LATCH_ME_BIT = 2;
    localparam int LATCH_EXT_BIT = 1;
    localparam int SRC_SEL_BIT = 0;
    localparam int EXT_CFG_MSB = 3;
    localparam int CODE2_LSB = 13;
    localparam int CODE1_LSB = 7;
    localparam int POS_BIT = 6;
    localparam int CHAN_LSB = 0;
    localparam logic [TEST_W-1:0] TEST_RESET = 19'h7_FFFF;

    localparam int STAMP_MEAS = 0;
    localparam int STAMP_SECOND = 1;
    localparam int STAMP_ANT = 2;
    localparam int STAMP_REAL = 3;
    localparam int STAMP_COMPLEX = 4;
    localparam int STAMP_AIDING = 5;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic [2:0] i;
        logic [2:0] q;
    } sample_t;

    typedef struct packed {
        logic measurement_epoch;
        logic second_pulse;
        logic real_power;
        logic complex_power;
        logic aiding_trigger;
    } event_t;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic [EXT_CFG_MSB:0] ext_cfg;
        logic [31:0] ext_live;
        logic [31:0] ext_held;
        logic [63:0] time_cnt;
        logic [63:0] preset;
        logic preset_pend;
        logic ant_en;
        logic [ANT_DIV_W-1:0] ant_div;
        logic [ANT_DIV_W-1:0] ant_cnt;
        logic ant_pin;
        logic [INT_W-1:0] epoch_int;
        logic [FRAC_W-1:0] epoch_frac;
        logic [TEST_W-1:0] test;
        logic [1:0] code_a;
        logic [1:0] code_b;
        sample_t sig_out;
        logic [31:0] rdata;
        logic rd_mem;
    } tsc_state_t;

    localparam tsc_state_t TSC_RESET = '{test: TEST_RESET, default: '0};

    function automatic logic chan_valid(input logic [SEL_W-1:0] sel);
        chan_valid = (sel < SEL_W'(NCH));
    endfunction : chan_valid

endpackage : tsc_pkg

// >>> frac_divider.sv
// Fractional divider that makes the epoch clock tick from the core clock.
`timescale 1ns/10ps
`default_nettype none
module frac_divider
    import tsc_pkg::*;
#(
    parameter int IW = INT_W,
    parameter int FW = FRAC_W
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Divisor settings
    input wire logic [IW-1:0] int_part,
    input wire logic [FW-1:0] frac_part,
    // Tick out
    output logic tick
);

    typedef struct packed {
        logic [IW-1:0] cnt;
        logic [FW-1:0] acc;
        logic tick;
    } div_state_t;

    div_state_t state_q;
    div_state_t state_d;
    logic [FW:0] acc_sum;

    assign acc_sum = {1'b0, state_q.acc} + {1'b0, frac_part};
    assign tick = state_q.tick;

    // New settings are sampled only when a period ends.
    always_comb
    begin
        state_d = state_q;
        state_d.tick = (state_q.cnt == '0);
        if (state_q.cnt == '0)
        begin
            state_d.acc = acc_sum[FW-1:0];
            state_d.cnt = int_part + IW'(acc_sum[FW]);
        end
        else
        begin
            state_d.cnt = state_q.cnt - IW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= '0;
        else
            state_q <= state_d;
    end

endmodule : frac_divider
`default_nettype wire

// >>> stamp_store.sv
// Small memory holding the time stamp pairs, with registered read data.
`timescale 1ns/10ps
`default_nettype none
module stamp_store
    import tsc_pkg::*;
#(
    parameter int N = NSTAMP,
    parameter int W = 32
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Pair write
    input wire logic [N-1:0] we,
    input wire logic [2*W-1:0] wdata,
    // Word read
    input wire logic [3:0] raddr,
    output logic [W-1:0] rdata
);

    typedef struct packed {
        logic [2*N-1:0][W-1:0] mem;
        logic [W-1:0] rdata;
    } store_state_t;

    store_state_t state_q;
    store_state_t state_d;

    assign rdata = state_q.rdata;

    always_comb
    begin
        state_d = state_q;
        for (int k = 0; k < N; k++)
        begin
            if (we[k])
            begin
                state_d.mem[2*k] = wdata[W-1:0];
                state_d.mem[2*k+1] = wdata[2*W-1:W];
            end
        end
        state_d.rdata = (int'(raddr) < 2*N) ? state_q.mem[raddr] : '0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= '0;
        else
            state_q <= state_d;
    end

endmodule : stamp_store
`default_nettype wire

// >>> timebase_stamp_counter.sv
// Time-base counters, time stamps and test output selection.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module timebase_stamp_counter
    import tsc_pkg::*;
#(
    parameter int CHANNELS = NCH
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire bus_req_t bus_req,
    output logic [31:0] rd_data,
    // Time-base events
    input wire event_t events,
    // External pins
    input wire logic external_count_pin,
    input wire logic external_core_pin,
    // Channel taps
    input wire logic [CHANNELS-1:0] chan_code,
    input wire logic [CHANNELS-1:0] chan_int_epoch,
    input wire sample_t [CHANNELS-1:0] sample_pre,
    input wire sample_t [CHANNELS-1:0] sample_post,
    // Output pins
    output logic antenna_epoch_out,
    output logic [1:0] code_test_pins_a,
    output logic [1:0] code_test_pins_b,
    output var sample_t sample_test_pins
);

    tsc_state_t state_q;
    tsc_state_t state_d;
    logic epoch_tick;
    logic antenna_switch_epoch;
    logic count_rise;
    logic trig_rise;
    logic latch_now;
    logic stamp_read;
    logic [NSTAMP-1:0] stamp_we;
    logic [5:0] word_addr;
    logic [3:0] stamp_addr;
    logic [31:0] stamp_rdata;
    logic [SEL_W-1:0] code1_sel;
    logic [SEL_W-1:0] code2_sel;
    logic [SEL_W-1:0] chan_sel;

    frac_divider #(
        .IW(INT_W),
        .FW(FRAC_W)
    ) u_epoch_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .int_part(state_q.epoch_int),
        .frac_part(state_q.epoch_frac),
        .tick(epoch_tick)
    );

    stamp_store #(
        .N(NSTAMP),
        .W(32)
    ) u_stamps (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .we(stamp_we),
        .wdata(state_q.time_cnt),
        .raddr(stamp_addr),
        .rdata(stamp_rdata)
    );

    // Edges are taken from the second synchroniser stage only.
    assign count_rise = state_q.ext_cfg[SRC_SEL_BIT] ?
        (state_q.sync2[1] && !state_q.prev[1]) :
        (state_q.sync2[0] && !state_q.prev[0]);
    assign trig_rise = state_q.sync2[1] && !state_q.prev[1];
    assign latch_now =
        (events.second_pulse && state_q.ext_cfg[LATCH_PPS_BIT]) ||
        (events.measurement_epoch && state_q.ext_cfg[LATCH_ME_BIT]) ||
        (trig_rise && state_q.ext_cfg[LATCH_EXT_BIT]);

    assign antenna_switch_epoch = epoch_tick && (state_q.ant_cnt == '0);

    always_comb
    begin
        stamp_we = '0;
        stamp_we[STAMP_MEAS] = events.measurement_epoch;
        stamp_we[STAMP_SECOND] = events.second_pulse;
        stamp_we[STAMP_ANT] = antenna_switch_epoch;
        stamp_we[STAMP_REAL] = events.real_power;
        stamp_we[STAMP_COMPLEX] = events.complex_power;
        stamp_we[STAMP_AIDING] = events.aiding_trigger;
    end

    assign word_addr = bus_req.addr[7:2] - STAMP_WORD_BASE;
    assign stamp_addr = word_addr[3:0];
    assign stamp_read = (bus_req.addr >= OFS_STAMP_BASE) &&
        (bus_req.addr <= OFS_STAMP_LAST) && (bus_req.addr[1:0] == 2'b00);

    assign code1_sel = state_q.test[CODE1_LSB +: SEL_W];
    assign code2_sel = state_q.test[CODE2_LSB +: SEL_W];
    assign chan_sel = state_q.test[CHAN_LSB +: SEL_W];

    assign rd_data = state_q.rd_mem ? stamp_rdata : state_q.rdata;
    assign antenna_epoch_out = state_q.ant_pin;
    assign code_test_pins_a = state_q.code_a;
    assign code_test_pins_b = state_q.code_b;
    assign sample_test_pins = state_q.sig_out;

    always_comb
    begin
        state_d = state_q;
        state_d.sync1 = {external_core_pin, external_count_pin};
        state_d.sync2 = state_q.sync1;
        state_d.prev = state_q.sync2;

        if (count_rise)
            state_d.ext_live = state_q.ext_live + 32'h0000_0001;
        if (latch_now)
            state_d.ext_held = state_q.ext_live;

        // A preset pending at the measurement epoch replaces the count.
        state_d.time_cnt = state_q.time_cnt + 64'h0000_0000_0000_0001;
        if (events.measurement_epoch && state_q.preset_pend)
        begin
            state_d.time_cnt = state_q.preset;
            state_d.preset_pend = 1'b0;
        end

        if (epoch_tick)
        begin
            if (state_q.ant_cnt == '0)
                state_d.ant_cnt = state_q.ant_div;
            else
                state_d.ant_cnt = state_q.ant_cnt - ANT_DIV_W'(1);
        end
        state_d.ant_pin = antenna_switch_epoch && state_q.ant_en;

        // A write to OFS_TIME_LOW or OFS_TIME_HIGH that meets the epoch keeps the preset pending.
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                OFS_EPOCH_DIV:
                begin
                    state_d.epoch_int = bus_req.wdata[INT_MSB:INT_LSB];
                    state_d.epoch_frac = bus_req.wdata[FRAC_MSB:0];
                end
                OFS_ANT_CTRL:
                begin
                    state_d.ant_en = bus_req.wdata[ANT_EN_BIT];
                    state_d.ant_div = bus_req.wdata[ANT_DIV_MSB:0];
                end
                OFS_EXT_CFG:
                    state_d.ext_cfg = bus_req.wdata[EXT_CFG_MSB:0];
                OFS_TIME_LOW:
                begin
                    state_d.preset[31:0] = bus_req.wdata;
                    state_d.preset_pend = 1'b1;
                end
                OFS_TIME_HIGH:
                begin
                    state_d.preset[63:32] = bus_req.wdata;
                    state_d.preset_pend = 1'b1;
                end
                OFS_TEST:
                    state_d.test = bus_req.wdata[TEST_W-1:0];
                default:
                    state_d.test = state_q.test;
            endcase
        end

        state_d.code_a = chan_valid(code1_sel) ?
            {chan_code[code1_sel], chan_int_epoch[code1_sel]} : 2'b00;
        state_d.code_b = chan_valid(code2_sel) ?
            {chan_code[code2_sel], chan_int_epoch[code2_sel]} : 2'b00;
        if (!chan_valid(chan_sel))
            state_d.sig_out = '0;
        else if (state_q.test[POS_BIT])
            state_d.sig_out = sample_post[chan_sel];
        else
            state_d.sig_out = sample_pre[chan_sel];

        // Read data stand for one cycle only; unmapped reads give zero.
        state_d.rdata = '0;
        state_d.rd_mem = bus_req.rd && stamp_read;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                OFS_EPOCH_DIV:
                begin
                    state_d.rdata[INT_MSB:INT_LSB] = state_q.epoch_int;
                    state_d.rdata[FRAC_MSB:0] = state_q.epoch_frac;
                end
                OFS_ANT_CTRL:
                begin
                    state_d.rdata[ANT_EN_BIT] = state_q.ant_en;
                    state_d.rdata[ANT_DIV_MSB:0] = state_q.ant_div;
                end
                OFS_EXT_CFG:
                    state_d.rdata[EXT_CFG_MSB:0] = state_q.ext_cfg;
                OFS_EXT_LIVE:
                    state_d.rdata = state_q.ext_live;
                OFS_EXT_HELD:
                    state_d.rdata = state_q.ext_held;
                OFS_TIME_LOW:
                    state_d.rdata = state_q.time_cnt[31:0];
                OFS_TIME_HIGH:
                    state_d.rdata = state_q.time_cnt[63:32];
                OFS_TEST:
                    state_d.rdata[TEST_W-1:0] = state_q.test;
                default:
                    state_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= TSC_RESET;
        else
            state_q <= state_d;
    end

    // Checks on the block's own outputs and state.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_ant_pin_gate: assert property (
        antenna_epoch_out |-> $past(state_q.ant_en) &&
            $past(antenna_switch_epoch))
        else $error("Antenna epoch pin pulsed while disabled.");

    a_ant_pin_fire: assert property (
        (antenna_switch_epoch && state_q.ant_en) |=> antenna_epoch_out)
        else $error("Antenna epoch pin missed an enabled epoch.");

    a_latch_second: assert property (
        (events.second_pulse && state_q.ext_cfg[LATCH_PPS_BIT])
            |=> state_q.ext_held == $past(state_q.ext_live))
        else $error("Held counter missed a second pulse latch.");

    a_latch_epoch: assert property (
        (events.measurement_epoch && state_q.ext_cfg[LATCH_ME_BIT])
            |=> state_q.ext_held == $past(state_q.ext_live))
        else $error("Held counter missed an epoch latch.");

    a_held_stable: assert property (
        !latch_now |=> $stable(state_q.ext_held))
        else $error("Held counter changed without a latch event.");

    a_count_step: assert property (
        $changed(state_q.ext_live) |->
            state_q.ext_live == $past(state_q.ext_live) + 32'h0000_0001)
        else $error("External counter moved by other than one.");

    a_preset_load: assert property (
        (events.measurement_epoch && state_q.preset_pend)
            |=> state_q.time_cnt == $past(state_q.preset))
        else $error("Time preset not applied at the epoch.");

    a_time_run: assert property (
        !events.measurement_epoch |=>
            state_q.time_cnt == $past(state_q.time_cnt) + 64'h1)
        else $error("Time counter did not advance by one.");

    a_code_ground: assert property (
        !chan_valid(code1_sel) ##1 $stable(code1_sel)
            |-> code_test_pins_a == 2'b00)
        else $error("Code test pins not grounded for idle select.");

    a_sample_ground: assert property (
        !chan_valid(chan_sel) ##1 $stable(chan_sel)
            |-> sample_test_pins == '0)
        else $error("Sample test pins not grounded for idle select.");

    a_read_window: assert property (
        (rd_data != '0) |-> $past(bus_req.rd))
        else $error("Read data present without a read one cycle before.");

    c_preset_epoch: cover property (
        events.measurement_epoch && state_q.preset_pend);
    c_ant_pulse: cover property (antenna_epoch_out);
    c_ext_latch: cover property (trig_rise && state_q.ext_cfg[LATCH_EXT_BIT]);
    c_stamp_read: cover property (state_q.rd_mem);

endmodule : timebase_stamp_counter
`default_nettype wire

// >>> timebase_stamp_counter_tb.sv
// Self-checking testbench for the time-base and stamp counter block.
`timescale 1ns/10ps
`default_nettype none
module timebase_stamp_counter_tb
    import tsc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n;
    bus_req_t bus_req = '0;
    logic [31:0] rd_data;
    event_t events = '0;
    logic external_count_pin = 1'b0;
    logic external_core_pin = 1'b0;
    logic [NCH-1:0] chan_code = 36'h9_3C5A_F0E1;
    logic [NCH-1:0] chan_int_epoch = 36'h6_C3A5_0F1E;
    sample_t [NCH-1:0] sample_pre;
    sample_t [NCH-1:0] sample_post;
    logic antenna_epoch_out;
    logic [1:0] code_test_pins_a;
    logic [1:0] code_test_pins_b;
    sample_t sample_test_pins;
    int miscompares = 0;
    int checks_done = 0;
    logic [31:0] d;
    logic [31:0] t;
    logic [31:0] v;
    int n;
    int sels [5] = '{0, 5, 35, 36, 63};
    logic [4:0] evs [5] = '{5'b10000, 5'b01000, 5'b00100, 5'b00010, 5'b00001};
    logic [7:0] sadr [5] = '{8'h30, 8'h38, 8'h48, 8'h50, 8'h58};

    timebase_stamp_counter timebase_stamp_counter_inst (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .events(events),
        .external_count_pin(external_count_pin),
        .external_core_pin(external_core_pin),
        .chan_code(chan_code),
        .chan_int_epoch(chan_int_epoch),
        .sample_pre(sample_pre),
        .sample_post(sample_post),
        .antenna_epoch_out(antenna_epoch_out),
        .code_test_pins_a(code_test_pins_a),
        .code_test_pins_b(code_test_pins_b),
        .sample_test_pins(sample_test_pins)
    );

    always #4 ref_clk = ~ref_clk;

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask : wr

    // Read strobe, optionally with event pulses in the same cycle.
    task automatic rd(input logic [7:0] a, input event_t ev,
                      output logic [31:0] q);
        @(posedge ref_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        events <= ev;
        @(posedge ref_clk);
        bus_req <= '0;
        events <= '0;
        @(negedge ref_clk);
        q = rd_data;
    endtask : rd

    task automatic rchk(input string name, input logic [7:0] a,
                        input logic [31:0] exp);
        logic [31:0] q;
        rd(a, '0, q);
        check(name, q, exp);
    endtask : rchk

    task automatic pins(input bit core, input int cnt);
        repeat (cnt)
        begin
            @(posedge ref_clk);
            if (core)
                external_core_pin <= 1'b1;
            else
                external_count_pin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            external_core_pin <= 1'b0;
            external_count_pin <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
        repeat (5) @(posedge ref_clk);
    endtask : pins

    task automatic wait_ant(output int cyc);
        cyc = 0;
        do
        begin
            @(negedge ref_clk);
            cyc++;
        end
        while (antenna_epoch_out !== 1'b1 && cyc < 100);
    endtask : wait_ant

    initial
    begin
        rst_n <= 1'b0;
        for (int i = 0; i < NCH; i++)
        begin
            sample_pre[i] = sample_t'(6'(i + 1));
            sample_post[i] = sample_t'(~6'(i));
        end
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk("ext_cfg_reset", OFS_EXT_CFG, 32'h0000_0000);
        rchk("live_reset", OFS_EXT_LIVE, 32'h0000_0000);
        rchk("held_reset", OFS_EXT_HELD, 32'h0000_0000);
        rchk("meas_stamp_reset", 8'h30, 32'h0000_0000);
        rchk("test_reset", OFS_TEST, 32'h0007_FFFF);
        rchk("unmapped", 8'h64, 32'h0000_0000);
        check("pins_reset", {22'h00_0000, code_test_pins_a, code_test_pins_b,
              sample_test_pins}, 32'h0000_0000);
        wr(OFS_EXT_CFG, 32'hFFFF_FFFF);
        rchk("ext_cfg_rw", OFS_EXT_CFG, 32'h0000_000F);
        wr(OFS_EXT_CFG, 32'h0000_0000);
        pins(0, 5);
        pins(1, 3);
        wr(OFS_EXT_LIVE, 32'h0000_0F0F);
        rchk("live_count_pin", OFS_EXT_LIVE, 32'h0000_0005);
        rchk("held_no_latch", OFS_EXT_HELD, 32'h0000_0000);
        wr(OFS_EXT_CFG, 32'h0000_0002);
        pins(1, 1);
        rchk("held_ext_trig", OFS_EXT_HELD, 32'h0000_0005);
        wr(OFS_EXT_CFG, 32'h0000_0004);
        pins(0, 3);
        rd(8'h64, event_t'(5'b10000), d);
        rchk("held_meas", OFS_EXT_HELD, 32'h0000_0008);
        wr(OFS_EXT_CFG, 32'h0000_0000);
        pins(0, 2);
        rd(8'h64, event_t'(5'b11000), d);
        rchk("held_disabled", OFS_EXT_HELD, 32'h0000_0008);
        wr(OFS_EXT_CFG, 32'h0000_0008);
        rd(8'h64, event_t'(5'b01000), d);
        rchk("held_second", OFS_EXT_HELD, 32'h0000_000A);
        wr(OFS_EXT_CFG, 32'h0000_0001);
        pins(1, 4);
        pins(0, 2);
        rchk("live_core_pin", OFS_EXT_LIVE, 32'h0000_000E);
        wr(OFS_TIME_LOW, 32'h0000_0100);
        wr(OFS_TIME_HIGH, 32'h0000_1234);
        rchk("time_high_running", OFS_TIME_HIGH, 32'h0000_0000);
        rd(8'h64, event_t'(5'b10000), d);
        rchk("time_high_preset", OFS_TIME_HIGH, 32'h0000_1234);
        rd(OFS_TIME_LOW, '0, t);
        check("time_low_preset", 32'((t - 32'h0000_0100) < 32'd40),
              32'h0000_0001);
        for (int i = 0; i < 5; i++)
        begin
            rd(OFS_TIME_LOW, event_t'(evs[i]), t);
            rchk("stamp_low", sadr[i], t);
            rchk("stamp_high", 8'(sadr[i] + 8'h04),
                 32'h0000_1234);
        end
        foreach (sels[k])
        begin
            v = {13'h0, 6'(63 - sels[k]), 6'(sels[k]), 1'(sels[k]),
                 6'(sels[k])};
            wr(OFS_TEST, v);
            rchk("test_rw", OFS_TEST, v);
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            check("code_a", {30'h0, code_test_pins_a}, sels[k] < 36 ?
                  {30'h0, chan_code[sels[k]], chan_int_epoch[sels[k]]}
                  : 32'h0000_0000);
            n = 63 - sels[k];
            check("code_b", {30'h0, code_test_pins_b}, n < 36 ?
                  {30'h0, chan_code[n], chan_int_epoch[n]}
                  : 32'h0000_0000);
            check("sample", {26'h0, sample_test_pins}, sels[k] >= 36 ?
                  32'h0000_0000 : sels[k] % 2 == 1 ?
                  {26'h0, sample_post[sels[k]]} :
                  {26'h0, sample_pre[sels[k]]});
        end
        wr(OFS_EPOCH_DIV, 32'h0000_0C00);
        wr(OFS_ANT_CTRL, 32'h0000_0401);
        wait_ant(n);
        wait_ant(n);
        wait_ant(n);
        check("ant_period", 32'(n), 32'h0000_0008);
        wr(OFS_EPOCH_DIV, 32'h0000_0E00);
        rchk("epoch_div_rw", OFS_EPOCH_DIV, 32'h0000_0E00);
        wait_ant(n);
        wait_ant(n);
        wait_ant(n);
        check("ant_period_frac", 32'(n), 32'h0000_0009);
        wr(OFS_EPOCH_DIV, 32'h0000_0C00);
        wr(OFS_ANT_CTRL, 32'h0000_0001);
        rchk("ant_ctrl_rw", OFS_ANT_CTRL, 32'h0000_0001);
        repeat (4) @(posedge ref_clk);
        n = 0;
        repeat (64)
        begin
            @(negedge ref_clk);
            if (antenna_epoch_out !== 1'b0)
                n++;
        end
        check("ant_disabled", 32'(n), 32'h0000_0000);
        rd(OFS_TIME_LOW, '0, t);
        rd(8'h40, '0, d);
        check("ant_stamp", 32'((t + 32'd2 - d) < 32'd9),
              32'h0000_0001);
        final_report();
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end

endmodule : timebase_stamp_counter_tb
`default_nettype wire
